/* tsr_top.sv */
// Purpose: temperature sensor register bank with serial slave and alert pin
// Assumes: converter delivers conv_data with a one-cycle conv_done pulse
// Notes:   writes land at the closing stop; reads stream msb then lsb
//
// Contract
// RL1: reserved capability and configuration bits ignore writes, read zero
// RL2: capability bit 7 picks freeze or clear of alert at shutdown
// RL3: capability bit 6 advertises a 25 to 35 ms bus time-out
// RL4: capability resolution code encodes the temperature lsb
// RL5: during shutdown clear-event may clear alert but nothing sets it
// RL6: hysteresis field selects off, 1.5, 3 or 6 degrees
// RL7: sensor off stops conversion and freezes the temperature
// RL8: critical lock blocks critical limit writes; only reset clears it
// RL9: alarm lock blocks high and low limit writes; only reset clears it
// RL10: clear-event self-clears, reads zero, acts in interrupt mode only
// RL11: clear-event has no effect while above the critical limit
// RL12: alert state reads asserted output, gated by output enable
// RL13: disabled output: released if active low, held low if active high
// RL14: critical-only limits events to critical crossings
// RL15: critical-only cannot be set while alarm lock is set
// RL16: alert pin is open drain; polarity 0 low, 1 high
// RL17: hysteresis, enable, polarity, mode frozen while a lock is set
// RL18: sensor off cannot be set under lock, may always be cleared
// RL19: sensor off is cleared at reset
// RL20: maker code and part revision registers are fixed
// RL21: mode bit 0 comparator, 1 interrupt
// RL22: writes to read-only or locked bits are acked, contents kept
// RL23: pointer selects capability register after reset
// RL24: write is address, pointer, two data bytes; applied at stop
`timescale 1ns/1ps
module tsr_top
    import tsr_pkg::*;
#(
    parameter int          TOUT_CYCLES = TOUT_CYC,
    parameter logic [15:0] MAKER_CODE  = 16'hA5C3, // arbitrary value
    parameter logic [15:0] PART_REV    = 16'h5E01  // arbitrary value
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic [2:0]  addr_sel,
    output logic             event_o,
    output logic             event_oe,
    input  wire logic [12:0] conv_data,
    input  wire logic        conv_done,
    output logic             conv_halt
);
    // ==========================================================
    // pin synchronisers
    logic       scl_m, scl_q, scl_p, sda_m, sda_q, sda_p;
    logic [2:0] adr_m, adr_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_m <= 1'b1; scl_q <= 1'b1; scl_p <= 1'b1;
            sda_m <= 1'b1; sda_q <= 1'b1; sda_p <= 1'b1;
            adr_m <= 3'h0; adr_q <= 3'h0;
        end
        else
        begin
            scl_m <= scl_i; scl_q <= scl_m; scl_p <= scl_q;
            sda_m <= sda_i; sda_q <= sda_m; sda_p <= sda_q;
            adr_m <= addr_sel; adr_q <= adr_m;
        end
    end
    wire start_det = scl_q & scl_p & sda_p & ~sda_q;
    wire stop_det  = scl_q & scl_p & ~sda_p & sda_q;
    wire scl_rise  = scl_q & ~scl_p;
    wire scl_fall  = ~scl_q & scl_p;

    // ==========================================================
    // register storage
    tsr_link_t   st_r;
    logic [2:0]  bit_r, ptr_r;
    logic [7:0]  sh_r, hi_r;
    logic [1:0]  idx_r, hysteresis_select_r;
    logic [15:0] wdat_r, hi_lim_r, lo_lim_r, crit_r, rd_word;
    logic [12:0] temp_r;
    logic [19:0] tout_r;
    logic        rd_r, ackd_r, wpend_r, wr_commit_r, txhi_r, sda_oe_r;
    logic        off_r, off_p_r, clock_r, alock_r, oen_r, conly_r, pol_r, mode_r;
    logic        alert_r, clr_pend_r, crit_t_r, high_t_r, low_t_r, win_p_r;
    logic        ev_oe_r, halt_r, low_drv_r;
    logic [13:0] hv;
    wire lock_any = clock_r | alock_r;
    wire tout_hit = (tout_r == 20'(TOUT_CYCLES - 1)); // RL3
    wire wcfg     = wr_commit_r && (ptr_r == OFF_CFG);
    wire clr_req  = wcfg & wdat_r[B_CLR] & mode_r; // RL10 RL21
    wire ev_sts   = alert_r & oen_r; // RL12
    wire [15:0] cfg_word = {5'h00, hysteresis_select_r, off_r, clock_r, alock_r, 1'b0, ev_sts,
                            oen_r, conly_r, pol_r, mode_r}; // RL1 RL10

    wire signed [13:0] t_s = $signed({temp_r[12], temp_r});
    wire signed [13:0] c_s = $signed({crit_r[12], crit_r[12:0]});
    wire signed [13:0] h_s = $signed({hi_lim_r[12], hi_lim_r[12:0]});
    wire signed [13:0] l_s = $signed({lo_lim_r[12], lo_lim_r[12:0]});
    wire signed [13:0] hv_s = $signed(hv);

    // ==========================================================
    // read mux
    always_comb
    begin
        case (ptr_r)
            OFF_CAPS: rd_word = CAPS_RST; // RL1 RL2 RL3 RL4
            OFF_CFG:  rd_word = cfg_word;
            OFF_HIGH: rd_word = hi_lim_r;
            OFF_LOW:  rd_word = lo_lim_r;
            OFF_CRIT: rd_word = crit_r;
            OFF_TEMP: rd_word = {t_s > c_s, t_s > h_s, t_s < l_s, temp_r};
            OFF_MAKR: rd_word = MAKER_CODE; // RL20
            default:  rd_word = PART_REV; // RL20
        endcase
    end

    // ==========================================================
    // serial slave engine
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= TSR_IDLE; bit_r <= 3'h0; sh_r <= 8'h00; hi_r <= 8'h00;
            idx_r <= 2'h0; rd_r <= 1'b0; ackd_r <= 1'b0; txhi_r <= 1'b0;
            ptr_r <= OFF_CAPS; // RL23
            wdat_r <= 16'h0000; wpend_r <= 1'b0; wr_commit_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            wr_commit_r <= 1'b0;
            if (start_det)
            begin
                st_r <= TSR_RX; bit_r <= 3'h0; idx_r <= 2'h0;
                wpend_r <= 1'b0; ackd_r <= 1'b0; sda_oe_r <= 1'b0;
            end
            else if (stop_det || tout_hit)
            begin
                st_r <= TSR_IDLE; sda_oe_r <= 1'b0; wpend_r <= 1'b0;
                ackd_r <= 1'b0;
                wr_commit_r <= stop_det & wpend_r; // RL24
            end
            else
            begin
                case (st_r)
                    TSR_RX:
                        if (scl_rise)
                        begin
                            sh_r <= {sh_r[6:0], sda_q};
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == 3'h7)
                                st_r <= TSR_ACK;
                        end
                    TSR_ACK:
                        if (scl_fall && !ackd_r)
                        begin
                            // every byte after a matching address is acked, even to read-only targets
                            ackd_r <= 1'b1; sda_oe_r <= 1'b1; // RL22
                            if (idx_r == 2'h0)
                            begin
                                rd_r <= sh_r[0];
                                if (sh_r[7:1] != {SLV_PREAMBLE, adr_q})
                                begin
                                    st_r <= TSR_IDLE; sda_oe_r <= 1'b0; ackd_r <= 1'b0;
                                end
                            end
                            else if (idx_r == 2'h1)
                                ptr_r <= sh_r[2:0];
                            else if (idx_r == 2'h2)
                                hi_r <= sh_r;
                            else if (!wpend_r)
                            begin
                                wdat_r <= {hi_r, sh_r}; wpend_r <= 1'b1; // RL24
                            end
                            if (idx_r != 2'h3)
                                idx_r <= idx_r + 2'h1;
                        end
                        else if (scl_fall)
                        begin
                            ackd_r <= 1'b0; bit_r <= 3'h0;
                            if (rd_r)
                            begin
                                st_r <= TSR_TX; sh_r <= rd_word[15:8];
                                sda_oe_r <= ~rd_word[15]; txhi_r <= 1'b1;
                            end
                            else
                            begin
                                st_r <= TSR_RX; sda_oe_r <= 1'b0;
                            end
                        end
                    TSR_TX:
                        if (scl_fall)
                        begin
                            sh_r <= {sh_r[6:0], 1'b0};
                            bit_r <= bit_r + 3'h1;
                            sda_oe_r <= (bit_r == 3'h7) ? 1'b0 : ~sh_r[6];
                            if (bit_r == 3'h7)
                                st_r <= TSR_TXACK;
                        end
                    TSR_TXACK:
                        if (scl_rise)
                            ackd_r <= ~sda_q;
                        else if (scl_fall)
                        begin
                            ackd_r <= 1'b0; bit_r <= 3'h0;
                            if (ackd_r)
                            begin
                                st_r <= TSR_TX; txhi_r <= ~txhi_r;
                                sh_r <= txhi_r ? rd_word[7:0] : rd_word[15:8];
                                sda_oe_r <= txhi_r ? ~rd_word[7] : ~rd_word[15];
                            end
                            else
                                st_r <= TSR_IDLE;
                        end
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // bus time-out: a stuck low clock frees the data line
    always_ff @(posedge clk)
    begin
        if (!rst_n || st_r == TSR_IDLE || scl_q || tout_hit)
            tout_r <= 20'h00000;
        else
            tout_r <= tout_r + 20'h00001; // RL3
    end

    // ==========================================================
    // configuration register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hysteresis_select_r <= 2'h0; off_r <= 1'b0; clock_r <= 1'b0; alock_r <= 1'b0; // RL19
            oen_r <= 1'b0; conly_r <= 1'b0; pol_r <= 1'b0; mode_r <= 1'b0;
        end
        else if (wcfg)
        begin
            clock_r <= clock_r | wdat_r[B_CLOCK]; // RL8
            alock_r <= alock_r | wdat_r[B_ALOCK]; // RL9
            if (!lock_any)
            begin
                hysteresis_select_r <= wdat_r[B_HYSTERESIS_SELECT +: 2]; // RL17
                oen_r  <= wdat_r[B_OEN];
                pol_r  <= wdat_r[B_POL];
                mode_r <= wdat_r[B_MODE];
            end
            conly_r <= alock_r ? (conly_r & wdat_r[B_CONLY]) : wdat_r[B_CONLY]; // RL15
            off_r   <= wdat_r[B_OFF] & (off_r | ~lock_any); // RL18
        end
    end

    // ==========================================================
    // limits and temperature
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hi_lim_r <= LIM_RST; lo_lim_r <= LIM_RST; crit_r <= LIM_RST;
        end
        else if (wr_commit_r)
        begin
            if (ptr_r == OFF_HIGH && !alock_r)
                hi_lim_r <= wdat_r & LIM_MASK; // RL9
            if (ptr_r == OFF_LOW && !alock_r)
                lo_lim_r <= wdat_r & LIM_MASK; // RL9
            if (ptr_r == OFF_CRIT && !clock_r)
                crit_r <= wdat_r & LIM_MASK; // RL8
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            temp_r <= TEMP_RST;
        else if (conv_done && !off_r)
            temp_r <= conv_data; // RL7
    end

    // ==========================================================
    // trip detection with hysteresis
    always_comb
    begin
        case (hysteresis_select_r)
            2'h1:    hv = HYSTERESIS_SELECT_1P5; // RL6
            2'h2:    hv = HYSTERESIS_SELECT_3;
            2'h3:    hv = HYSTERESIS_SELECT_6;
            default: hv = 14'h0000;
        endcase
    end

    // trips hold the pre-shutdown picture so the pin keeps its state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            crit_t_r <= 1'b0; high_t_r <= 1'b0; low_t_r <= 1'b0; win_p_r <= 1'b0;
        end
        else if (!off_r)
        begin
            crit_t_r <= (t_s > c_s) | (crit_t_r & (t_s > c_s - hv_s));
            high_t_r <= (t_s > h_s) | (high_t_r & (t_s > h_s - hv_s));
            low_t_r  <= (t_s < l_s) | (low_t_r & (t_s < l_s + hv_s));
            win_p_r  <= conly_r ? crit_t_r : (crit_t_r | high_t_r | low_t_r);
        end
    end
    wire win = conly_r ? crit_t_r : (crit_t_r | high_t_r | low_t_r); // RL14

    // ==========================================================
    // alert state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            alert_r <= 1'b0; clr_pend_r <= 1'b0; off_p_r <= 1'b0;
        end
        else
        begin
            off_p_r <= off_r;
            if (off_r && !off_p_r && CAPS_RST[CAP_SHUTDOWN_EVENT_BEHAVIOUR])
                alert_r <= 1'b0; // RL2
            else if (off_r)
            begin
                if (clr_req && !crit_t_r)
                    alert_r <= 1'b0; // RL5
            end
            else if (!mode_r)
                alert_r <= win; // RL21
            else if (crit_t_r || win != win_p_r)
                alert_r <= 1'b1;
            else if (clr_req || clr_pend_r)
                alert_r <= 1'b0; // RL10
            // a clear seen above critical waits until the trip drops
            if (!mode_r || !crit_t_r)
                clr_pend_r <= 1'b0;
            else if (clr_req)
                clr_pend_r <= 1'b1; // RL11
        end
    end

    // ==========================================================
    // pins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ev_oe_r <= 1'b0; halt_r <= 1'b0; low_drv_r <= 1'b0;
        end
        else
        begin
            ev_oe_r <= pol_r ? ~ev_sts : ev_sts; // RL13 RL16
            halt_r  <= off_r; // RL7
        end
    end
    assign event_o   = low_drv_r;
    assign event_oe  = ev_oe_r;
    assign sda_o     = low_drv_r;
    assign sda_oe    = sda_oe_r;
    assign conv_halt = halt_r;

    // ==========================================================
    // checks
    property p_rsv_zero;
        @(posedge clk) disable iff (!rst_n) wcfg |=> cfg_word[15:11] == 5'h00 && !cfg_word[B_CLR];
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved or clear bit reads one"); // RL1

    property p_crit_lock;
        @(posedge clk) disable iff (!rst_n)
            clock_r && wr_commit_r && ptr_r == OFF_CRIT |=> $stable(crit_r);
    endproperty
    a_crit_lock: assert property (p_crit_lock) else $error("locked critical limit changed"); // RL8

    property p_alarm_lock;
        @(posedge clk) disable iff (!rst_n)
            alock_r && wr_commit_r |=> $stable(hi_lim_r) && $stable(lo_lim_r);
    endproperty
    a_alarm_lock: assert property (p_alarm_lock) else $error("locked alarm limit changed"); // RL9

    property p_off_lock;
        @(posedge clk) disable iff (!rst_n) lock_any && !off_r |=> !off_r;
    endproperty
    a_off_lock: assert property (p_off_lock) else $error("shutdown set under lock"); // RL18

    property p_conly_lock;
        @(posedge clk) disable iff (!rst_n) alock_r && !conly_r |=> !conly_r;
    endproperty
    a_conly_lock: assert property (p_conly_lock) else $error("critical-only set under lock"); // RL15

    property p_fields_lock;
        @(posedge clk) disable iff (!rst_n)
            lock_any |=> $stable(hysteresis_select_r) && $stable(oen_r) && $stable(pol_r) && $stable(mode_r);
    endproperty
    a_fields_lock: assert property (p_fields_lock) else $error("locked field changed"); // RL17

    property p_pin_off;
        @(posedge clk) disable iff (!rst_n) !oen_r |=> event_oe == $past(pol_r);
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin level wrong"); // RL13

    property p_sd_freeze;
        @(posedge clk) disable iff (!rst_n) $rose(off_r) && !clr_req |=> $stable(alert_r);
    endproperty
    a_sd_freeze: assert property (p_sd_freeze) else $error("alert moved at shutdown"); // RL2

    property p_commit_stop;
        @(posedge clk) disable iff (!rst_n) wr_commit_r |-> $past(stop_det);
    endproperty
    a_commit_stop: assert property (p_commit_stop) else $error("write applied without stop"); // RL24
endmodule

/* tsr_pkg.sv */
// Purpose: constants and types of the temperature sensor register bank
// Assumes: 25 MHz system clock, serial pins sampled in that domain
// Notes:   register offsets are 3-bit pointer values
package tsr_pkg;
    // ==========================================================
    // register offsets
    localparam logic [2:0]  OFF_CAPS = 3'h0;
    localparam logic [2:0]  OFF_CFG  = 3'h1;
    localparam logic [2:0]  OFF_HIGH = 3'h2;
    localparam logic [2:0]  OFF_LOW  = 3'h3;
    localparam logic [2:0]  OFF_CRIT = 3'h4;
    localparam logic [2:0]  OFF_TEMP = 3'h5;
    localparam logic [2:0]  OFF_MAKR = 3'h6;
    localparam logic [2:0]  OFF_PART = 3'h7;
    // ==========================================================
    // reset values and masks
    localparam logic [15:0] CAPS_RST = 16'h0077;
    localparam logic [15:0] LIM_RST  = 16'h0000;
    localparam logic [12:0] TEMP_RST = 13'h0000;
    localparam logic [15:0] LIM_MASK = 16'h1FFC;
    // ==========================================================
    // configuration and capability field positions
    localparam int B_HYSTERESIS_SELECT  = 9;
    localparam int B_OFF   = 8;
    localparam int B_CLOCK = 7;
    localparam int B_ALOCK = 6;
    localparam int B_CLR   = 5;
    localparam int B_OEN   = 3;
    localparam int B_CONLY = 2;
    localparam int B_POL   = 1;
    localparam int B_MODE  = 0;
    localparam int CAP_SHUTDOWN_EVENT_BEHAVIOUR = 7;
    // ==========================================================
    // hysteresis in 1/16 degree steps
    localparam logic [13:0] HYSTERESIS_SELECT_1P5 = 14'h0018;
    localparam logic [13:0] HYSTERESIS_SELECT_3   = 14'h0030;
    localparam logic [13:0] HYSTERESIS_SELECT_6   = 14'h0060;
    // ==========================================================
    // serial link
    localparam logic [3:0]  SLV_PREAMBLE = 4'h3;
    localparam int CLK_KHZ      = 25000;
    localparam int TOUT_MIN_MS  = 25;
    localparam int TOUT_CYC     = TOUT_MIN_MS * CLK_KHZ;
    typedef enum {TSR_IDLE, TSR_RX, TSR_ACK, TSR_TX, TSR_TXACK} tsr_link_t;
endpackage

/* tsr_host.sv */
// Purpose: serial bus host model driving the sensor's clock and data pins
// Assumes: both lines pulled up; one bit takes 8 clk (320 ns)
// Notes:   scl stands high between frames; a released sda reads high
`timescale 1ns/1ps
module tsr_host
    import tsr_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_pull
);
    // ==========================================================
    // bit level: every change lands just after a clk edge
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic put_bit(input logic b);
        tick(2);
        sda_pull <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    // sampled at a falling clk edge so the slave's update has landed
    task automatic get_bit(output logic b);
        tick(2);
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        @(negedge clk);
        b = sda_in;
        tick(1);
        scl <= 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b0;
        tick(4);
    endtask
    // ==========================================================
    // byte level: a missing ack adds one to nak
    task automatic tx(input logic [7:0] d, inout int nak);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        nak += int'(b);
    endtask
    task automatic rx(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(last);
    endtask
    // ==========================================================
    // register level
    task automatic wr(input logic [2:0] adr, input logic [2:0] ptr,
                      input logic [15:0] data, output int nak);
        nak = 0;
        start();
        tx({SLV_PREAMBLE, adr, 1'b0}, nak);
        tx({5'h00, ptr}, nak);
        tx(data[15:8], nak);
        tx(data[7:0], nak);
        stop();
    endtask
    // sel low gives an immediate read from the current pointer
    task automatic rd(input logic [2:0] adr, input logic [2:0] ptr, input logic sel,
                      output logic [15:0] data, output int nak);
        nak = 0;
        if (sel)
        begin
            start();
            tx({SLV_PREAMBLE, adr, 1'b0}, nak);
            tx({5'h00, ptr}, nak);
        end
        start();
        tx({SLV_PREAMBLE, adr, 1'b1}, nak);
        rx(data[15:8], 1'b0);
        rx(data[7:0], 1'b1);
        stop();
    endtask
endmodule

/* tsr_top_tb.sv */
// Purpose: self-checking bench for the sensor register bank
// Assumes: host model on the serial pins, converter pulses from here
// Notes:   time-out shortened to 200 clk; identity values arbitrary
`timescale 1ns/1ps
module tsr_top_tb
    import tsr_pkg::*;
;
    localparam logic [2:0]  ADR   = 3'h5;
    localparam logic [15:0] MAKER = 16'h3C5A; // arbitrary value
    localparam logic [15:0] PART  = 16'h0E17; // arbitrary value
    localparam logic [7:0]  ADW   = {SLV_PREAMBLE, ADR, 1'b0};
    logic        clk;
    logic        rst_n;
    logic        scl;
    logic        sda_pull;
    logic        sda_o;
    logic        sda_oe;
    logic        event_o;
    logic        event_oe;
    logic        conv_done;
    logic        conv_halt;
    logic [12:0] conv_data;
    logic [15:0] d;
    int          nak;
    int          n_fail;
    int          total_checks;
    logic [15:0] wv [9] = '{16'h0008, 16'h000A, 16'h0002, 16'h0000, 16'h000C,
                            16'h0028, 16'h0208, 16'h0408, 16'h0608};
    logic [15:0] rv [9] = '{16'h0018, 16'h001A, 16'h0002, 16'h0000, 16'h000C,
                            16'h0018, 16'h0218, 16'h0418, 16'h0618};
    logic        ov [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    // wired line: pull-up unless someone pulls low
    wire logic   sda = ~(sda_pull | sda_oe);
    // ==========================================================
    // design and host
    tsr_top #(.TOUT_CYCLES(200), .MAKER_CODE(MAKER), .PART_REV(PART)) u_dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .scl_i     (scl),
        .sda_i     (sda),
        .sda_o     (sda_o),
        .sda_oe    (sda_oe),
        .addr_sel  (ADR),
        .event_o   (event_o),
        .event_oe  (event_oe),
        .conv_data (conv_data),
        .conv_done (conv_done),
        .conv_halt (conv_halt)
    );
    tsr_host u_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_pull(sda_pull));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // settle past the commit at stop before anything is looked at
    task automatic ww(input logic [2:0] ptr, input logic [15:0] v);
        u_host.wr(ADR, ptr, v, nak);
        chk("write acks", 16'(nak), 16'h0000);
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rr(input logic [2:0] ptr, input logic [15:0] exp);
        u_host.rd(ADR, ptr, 1'b1, d, nak);
        chk("read acks", 16'(nak), 16'h0000);
        chk($sformatf("reg %0d", ptr), d, exp);
    endtask
    task automatic conv(input logic [12:0] v);
        @(posedge clk);
        conv_data <= v;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #2400000;
        n_fail++;
        conclude();
    end
    // ==========================================================
    // tests
    initial
    begin
        rst_n     = 1'b0;
        conv_done = 1'b0;
        conv_data = 13'h0000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("conv_halt", 16'(conv_halt), 16'h0000);
        chk("event_oe", 16'(event_oe), 16'h0000);
        chk("event_o", 16'(event_o), 16'h0000);
        chk("sda_o", 16'(sda_o), 16'h0000);
        u_host.rd(ADR, 3'h3, 1'b0, d, nak);
        chk("immediate read", d, 16'h0077);
        rr(OFF_CAPS, 16'h0077);
        for (int i = 1; i < 6; i++)
            rr(3'(i), 16'h0000);
        rr(OFF_MAKR, MAKER);
        rr(OFF_PART, PART);
        u_host.wr(ADR ^ 3'h1, OFF_HIGH, 16'h0100, nak);
        chk("foreign address acks", 16'(nak), 16'h0004);
        ww(OFF_CAPS, 16'hFFFF);
        ww(OFF_MAKR, 16'h0000);
        rr(OFF_CAPS, 16'h0077);
        rr(OFF_MAKR, MAKER);
        ww(OFF_CFG, 16'hF800);
        rr(OFF_CFG, 16'h0000);
        ww(OFF_HIGH, 16'hE322);
        ww(OFF_LOW, 16'h0190);
        ww(OFF_CRIT, 16'h07D0);
        rr(OFF_HIGH, 16'h0320);
        conv(13'h0400);
        rr(OFF_TEMP, 16'h4400);
        // output stage, polarity, critical-only, clear in comparator, hysteresis
        for (int i = 0; i < 9; i++)
        begin
            ww(OFF_CFG, wv[i]);
            chk("event_oe", 16'(event_oe), 16'(ov[i]));
            rr(OFF_CFG, rv[i]);
        end
        ww(OFF_CFG, 16'h0009);
        conv(13'h0190);
        chk("event_oe", 16'(event_oe), 16'h0001);
        ww(OFF_CFG, 16'h0029);
        chk("event_oe", 16'(event_oe), 16'h0000);
        rr(OFF_CFG, 16'h0009);
        conv(13'h0400);
        ww(OFF_CFG, 16'h0109);
        chk("conv_halt", 16'(conv_halt), 16'h0001);
        chk("event_oe", 16'(event_oe), 16'h0001);
        conv(13'h0190);
        rr(OFF_TEMP, 16'h4400);
        ww(OFF_CFG, 16'h0129);
        chk("event_oe", 16'(event_oe), 16'h0000);
        conv(13'h07E0);
        chk("event_oe", 16'(event_oe), 16'h0000);
        ww(OFF_CFG, 16'h0009);
        chk("conv_halt", 16'(conv_halt), 16'h0000);
        conv(13'h07E0);
        ww(OFF_CFG, 16'h0029);
        chk("event_oe", 16'(event_oe), 16'h0001);
        ww(OFF_CFG, 16'h0089);
        ww(OFF_CRIT, 16'h0100);
        rr(OFF_CRIT, 16'h07D0);
        ww(OFF_HIGH, 16'h0324);
        rr(OFF_HIGH, 16'h0324);
        ww(OFF_CFG, 16'h00C9);
        ww(OFF_LOW, 16'h0000);
        rr(OFF_LOW, 16'h0190);
        ww(OFF_CFG, 16'h0736);
        rr(OFF_CFG, 16'h00D9);
        // hold the clock low inside the address ack until the time-out frees the line
        u_host.start();
        for (int i = 7; i >= 0; i--)
            u_host.put_bit(ADW[i]);
        repeat (20) @(negedge clk);
        chk("ack held", 16'(sda_oe), 16'h0001);
        repeat (200) @(negedge clk);
        chk("time-out release", 16'(sda_oe), 16'h0000);
        u_host.stop();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rr(OFF_CFG, 16'h0000);
        conclude();
    end
endmodule
